//--- src/cd_clock_dist.sv
/*
 * Clock distribution: master clock choice, bus and CPU dividers, eight
 * digital and four analog dividers, USB clock selection.
 * Assumes source clocks are slower than half of i_clock and that the
 * register port master keeps the documented strobe discipline.
 */
// Notes on behaviour
// - Seven sources enter and the fastest one is chosen as master clock.
// - A 16-bit divider fed by the master clock makes the bus clock.
// - The CPU divider counts bus clock edges only.
// - Eight 16-bit digital dividers can each use any of the seven sources.
// - Four 16-bit analog dividers have programmable output skew.
// - Each digital and analog divider picks its input through its own eight-way mux.
// - Ratios are two or more, with an output close to half duty.
// - Outputs are resynchronised to the master clock and free of runts.
// - A digital output can leave and return as a source for chaining.
// - USB uses 48 MHz direct or a doubled 24 MHz source.
// - USB control is updated in step with the bus clock.
`timescale 1ns/1ns
`default_nettype none

module cd_clock_dist
    import cd_pkg::*;
(
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_rst,
    // Clock sources and interconnect return
    input wire logic [CD_NSRC-1:0] i_src,
    input wire logic i_chain,
    // Register port
    input wire logic [CD_AW-1:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    // Clock outputs
    output logic [CD_SELW-1:0] o_mclk_sel,
    output logic o_bus_clk,
    output logic o_cpu_clk,
    output logic [CD_NDIG-1:0] o_dclk,
    output logic [CD_NANA-1:0] o_aclk,
    // USB clock control
    output logic [1:0] o_usb_sel,
    output logic o_usb_dbl_en
);

    ////////////////////////////////////////////////////////////////////////
    // Source synchronisers and tick extraction.

    logic [CD_NMUX-1:0] src_meta_r;
    logic [CD_NMUX-1:0] src_sync_r;
    logic [CD_NMUX-1:0] src_prev_r;
    wire logic [CD_NMUX-1:0] src_tick_w;

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            src_meta_r <= '0;
            src_sync_r <= '0;
            src_prev_r <= '0;
        end else begin
            src_meta_r <= {i_chain, i_src};
            src_sync_r <= src_meta_r;
            src_prev_r <= src_sync_r;
        end
    end

    assign src_tick_w = src_sync_r & ~src_prev_r;

    ////////////////////////////////////////////////////////////////////////
    // Register decode.

    logic [31:0] mclk_cfg_r;
    logic [31:0] bus_cfg_r;
    logic [31:0] cpu_cfg_r;
    logic [31:0] dig_cfg_r [CD_NDIG];
    logic [31:0] ana_cfg_r [CD_NANA];
    logic [1:0] usb_pend_r;
    logic [1:0] usb_sel_r;
    logic usb_dbl_r;
    logic [31:0] rdata_r;
    wire logic hit_mclk;
    wire logic hit_bus;
    wire logic hit_cpu;
    wire logic hit_usb;
    wire logic hit_stat;
    wire logic hit_dig;
    wire logic hit_ana;
    wire logic hit_any;
    wire logic [CD_SELW-1:0] dig_idx;
    wire logic [CD_SKEWW-1:0] ana_idx;
    wire logic [31:0] stat_w;
    wire logic [31:0] usb_w;
    wire logic [31:0] rd_val;
    wire logic bus_rise;

    assign hit_mclk = (i_addr == CD_OFF_MCLK);
    assign hit_bus = (i_addr == CD_OFF_BUS);
    assign hit_cpu = (i_addr == CD_OFF_CPU);
    assign hit_usb = (i_addr == CD_OFF_USB);
    assign hit_stat = (i_addr == CD_OFF_STAT);
    assign hit_dig = (i_addr >= CD_OFF_DIG) && (i_addr < CD_OFF_DIG_END);
    assign hit_ana = (i_addr >= CD_OFF_ANA) && (i_addr < CD_OFF_ANA_END);
    assign hit_any = hit_mclk || hit_bus || hit_cpu || hit_usb
                     || hit_stat || hit_dig || hit_ana;
    assign dig_idx = i_addr[CD_IDX_LSB +: CD_SELW];
    assign ana_idx = i_addr[CD_IDX_LSB +: CD_SKEWW];

    assign stat_w = {{(32-CD_NANA-CD_NDIG-2){1'b0}},
                     o_aclk, o_dclk, o_cpu_clk, o_bus_clk};
    assign usb_w = {{(32-CD_USB_ACT_LSB-2){1'b0}}, usb_sel_r,
                    {(CD_USB_ACT_LSB-2){1'b0}}, usb_pend_r};

    assign rd_val = hit_mclk ? mclk_cfg_r :
                    hit_bus ? bus_cfg_r :
                    hit_cpu ? cpu_cfg_r :
                    hit_usb ? usb_w :
                    hit_stat ? stat_w :
                    hit_dig ? dig_cfg_r[dig_idx] :
                    hit_ana ? ana_cfg_r[ana_idx] : '0;

    // Read data stand for exactly one cycle; unmapped reads give zero.
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            rdata_r <= '0;
        end else begin
            rdata_r <= i_rd ? rd_val : '0;
        end
    end

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            mclk_cfg_r <= CD_MCLK_RST;
            bus_cfg_r <= CD_CFG_RST;
            cpu_cfg_r <= CD_CFG_RST;
            usb_pend_r <= CD_USB_DSI48;
        end else if (i_wr) begin
            if (hit_mclk) begin
                mclk_cfg_r <= i_wdata & CD_MCLK_MASK;
            end
            if (hit_bus) begin
                bus_cfg_r <= {16'h0000, i_wdata[CD_DIVW-1:0]};
            end
            if (hit_cpu) begin
                cpu_cfg_r <= {16'h0000, i_wdata[CD_DIVW-1:0]};
            end
            if (hit_usb) begin
                usb_pend_r <= i_wdata[1:0];
            end
        end
    end

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            for (int i = 0; i < CD_NDIG; i++) begin
                dig_cfg_r[i] <= CD_CFG_RST;
            end
            for (int i = 0; i < CD_NANA; i++) begin
                ana_cfg_r[i] <= CD_CFG_RST;
            end
        end else if (i_wr) begin
            for (int i = 0; i < CD_NDIG; i++) begin
                if (hit_dig && dig_idx == CD_SELW'(i)) begin
                    dig_cfg_r[i] <= i_wdata & CD_DIG_MASK;
                end
            end
            for (int i = 0; i < CD_NANA; i++) begin
                if (hit_ana && ana_idx == CD_SKEWW'(i)) begin
                    ana_cfg_r[i] <= i_wdata & CD_ANA_MASK;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Master clock choice by counting source edges over a window.

    logic [CD_MEASW-1:0] win_r;
    logic [CD_MEASW-1:0] meas_r [CD_NSRC];
    logic [CD_SELW-1:0] mclk_sel_r;
    logic [CD_SELW-1:0] best_w;
    logic [CD_MEASW-1:0] best_cnt_w;
    wire logic win_end;

    assign win_end = (win_r == CD_MEAS_LAST);

    always_comb begin
        best_w = '0;
        best_cnt_w = meas_r[0];
        for (int k = 1; k < CD_NSRC; k++) begin
            if (meas_r[k] > best_cnt_w) begin
                best_cnt_w = meas_r[k];
                best_w = CD_SELW'(k);
            end
        end
    end

    // Counters saturate, so two very fast sources tie to the lower index.
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            win_r <= '0;
            for (int k = 0; k < CD_NSRC; k++) begin
                meas_r[k] <= '0;
            end
        end else begin
            win_r <= win_r + 1'b1;
            for (int k = 0; k < CD_NSRC; k++) begin
                if (win_end) begin
                    meas_r[k] <= '0;
                end else if (src_tick_w[k] && meas_r[k] != CD_MEAS_LAST) begin
                    meas_r[k] <= meas_r[k] + 1'b1;
                end
            end
        end
    end

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            mclk_sel_r <= '0;
        end else if (!mclk_cfg_r[CD_MCLK_AUTO_BIT]) begin
            mclk_sel_r <= mclk_cfg_r[CD_MCLK_SEL_LSB +: CD_SELW];
        end else if (win_end) begin
            mclk_sel_r <= best_w;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Divider instances.

    cd_div_if bus_if();
    cd_div_if cpu_if();
    wire logic [CD_NDIG-1:0] dclk_w;
    wire logic [CD_NANA-1:0] aclk_w;

    assign bus_if.div = bus_cfg_r[CD_DIVW-1:0];
    assign bus_if.sel = '0;
    assign bus_if.skew = '0;
    assign bus_if.ticks = '1;
    assign bus_rise = bus_if.rise;

    cd_divider #(.SKEW_EN(1'b0)) u_bus (
        .i_clock(i_clock),
        .i_rst(i_rst),
        .port(bus_if.div_end)
    );

    assign cpu_if.div = cpu_cfg_r[CD_DIVW-1:0];
    assign cpu_if.sel = '0;
    assign cpu_if.skew = '0;
    assign cpu_if.ticks = {CD_NMUX{bus_rise}};

    cd_divider #(.SKEW_EN(1'b0)) u_cpu (
        .i_clock(i_clock),
        .i_rst(i_rst),
        .port(cpu_if.div_end)
    );

    for (genvar gi = 0; gi < CD_NDIG; gi++) begin : g_dig
        cd_div_if u_if();
        assign u_if.div = dig_cfg_r[gi][CD_DIVW-1:0];
        assign u_if.sel = dig_cfg_r[gi][CD_SEL_LSB +: CD_SELW];
        assign u_if.skew = '0;
        assign u_if.ticks = src_tick_w;
        cd_divider #(.SKEW_EN(1'b0)) u_div (
            .i_clock(i_clock),
            .i_rst(i_rst),
            .port(u_if.div_end)
        );
        assign dclk_w[gi] = u_if.clk;
    end

    for (genvar gi = 0; gi < CD_NANA; gi++) begin : g_ana
        cd_div_if u_if();
        assign u_if.div = ana_cfg_r[gi][CD_DIVW-1:0];
        assign u_if.sel = ana_cfg_r[gi][CD_SEL_LSB +: CD_SELW];
        assign u_if.skew = ana_cfg_r[gi][CD_SKEW_LSB +: CD_SKEWW];
        assign u_if.ticks = src_tick_w;
        cd_divider #(.SKEW_EN(1'b1)) u_div (
            .i_clock(i_clock),
            .i_rst(i_rst),
            .port(u_if.div_end)
        );
        assign aclk_w[gi] = u_if.clk;
    end

    ////////////////////////////////////////////////////////////////////////
    // USB clock selection, applied on bus clock edges only.

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            usb_sel_r <= CD_USB_DSI48;
            usb_dbl_r <= 1'b0;
        end else if (bus_rise) begin
            usb_sel_r <= usb_pend_r;
            usb_dbl_r <= (usb_pend_r != CD_USB_DSI48);
        end
    end

    assign o_rdata = rdata_r;
    assign o_mclk_sel = mclk_sel_r;
    assign o_bus_clk = bus_if.clk;
    assign o_cpu_clk = cpu_if.clk;
    assign o_dclk = dclk_w;
    assign o_aclk = aclk_w;
    assign o_usb_sel = usb_sel_r;
    assign o_usb_dbl_en = usb_dbl_r;

    ////////////////////////////////////////////////////////////////////////
    // Checks.

    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_rst);

    AST_CPU_FROM_BUS: assert property (
        $rose(o_cpu_clk) |-> $past(bus_rise, 2))
        else $error("cpu clock rose without a bus clock edge");
    AST_BUS_WRITE: assert property (
        i_wr && hit_bus |=> bus_if.div == $past(i_wdata[CD_DIVW-1:0]))
        else $error("bus divisor not stored");
    AST_MCLK_AUTO: assert property (
        win_end && mclk_cfg_r[CD_MCLK_AUTO_BIT]
        |=> o_mclk_sel == $past(best_w))
        else $error("master clock choice not the fastest source");
    AST_USB_ON_BUS: assert property (
        $changed(o_usb_sel) |-> $past(bus_rise))
        else $error("usb select moved off a bus clock edge");
    AST_USB_DBL: assert property (
        o_usb_dbl_en == (o_usb_sel != CD_USB_DSI48))
        else $error("doubler enable disagrees with usb source");
    AST_UNMAPPED: assert property (i_rd && !hit_any |=> o_rdata == '0)
        else $error("unmapped read returned data");

endmodule : cd_clock_dist

`default_nettype wire

//--- common/cd_pkg.sv
/*
 * Shared constants and types of the clock distribution block.
 * Assumes a single master clock domain with a 32-bit register port.
 */
`default_nettype none

package cd_pkg;

    localparam int CD_NSRC = 7;
    localparam int CD_NMUX = 8;
    localparam int CD_NDIG = 8;
    localparam int CD_NANA = 4;
    localparam int CD_DIVW = 16;
    localparam int CD_SELW = 3;
    localparam int CD_SKEWW = 2;
    localparam int CD_DLY = 2 ** CD_SKEWW;
    localparam int CD_AW = 8;
    localparam int CD_MEASW = 8;
    localparam int CD_IDX_LSB = 2;
    localparam int CD_CHAIN_IDX = 7;

    localparam logic [CD_AW-1:0] CD_OFF_MCLK = 8'h00;
    localparam logic [CD_AW-1:0] CD_OFF_BUS = 8'h04;
    localparam logic [CD_AW-1:0] CD_OFF_CPU = 8'h08;
    localparam logic [CD_AW-1:0] CD_OFF_USB = 8'h0c;
    localparam logic [CD_AW-1:0] CD_OFF_STAT = 8'h10;
    localparam logic [CD_AW-1:0] CD_OFF_DIG = 8'h20;
    localparam logic [CD_AW-1:0] CD_OFF_DIG_END = 8'h40;
    localparam logic [CD_AW-1:0] CD_OFF_ANA = 8'h40;
    localparam logic [CD_AW-1:0] CD_OFF_ANA_END = 8'h50;

    localparam int CD_SEL_LSB = 16;
    localparam int CD_SKEW_LSB = 20;
    localparam int CD_MCLK_AUTO_BIT = 0;
    localparam int CD_MCLK_SEL_LSB = 4;
    localparam int CD_USB_ACT_LSB = 4;

    localparam logic [31:0] CD_CFG_RST = 32'h0000_0002;
    localparam logic [31:0] CD_DIG_MASK = 32'h0007_ffff;
    localparam logic [31:0] CD_ANA_MASK = 32'h0037_ffff;
    localparam logic [31:0] CD_MCLK_RST = 32'h0000_0001;
    localparam logic [31:0] CD_MCLK_MASK = 32'h0000_0071;
    localparam logic [CD_DIVW-1:0] CD_DIV_MIN = 16'h0002;
    localparam logic [CD_DIVW-1:0] CD_DIV_ONE = 16'h0001;
    localparam logic [CD_MEASW-1:0] CD_MEAS_LAST = 8'hff;

    typedef enum logic [1:0] {
        CD_USB_DSI48,
        CD_USB_IMO_X2,
        CD_USB_DSI_X2,
        CD_USB_XTAL_X2
    } cd_usb_src_type;

endpackage : cd_pkg

`default_nettype wire

//--- common/cd_div_if.sv
/*
 * Configuration and output bundle of one clock divider.
 * Assumes the control side drives settings and source ticks.
 */
`timescale 1ns/1ns
`default_nettype none

interface cd_div_if;
    import cd_pkg::*;
    logic [CD_DIVW-1:0] div;
    logic [CD_SELW-1:0] sel;
    logic [CD_SKEWW-1:0] skew;
    logic [CD_NMUX-1:0] ticks;
    logic clk;
    logic rise;
    modport ctrl (output div, sel, skew, ticks, input clk, rise);
    modport div_end (input div, sel, skew, ticks, output clk, rise);
endinterface : cd_div_if

`default_nettype wire

//--- src/cd_divider.sv
/*
 * One 16-bit clock divider: source mux, counter, skew taps and
 * master clock resynchronisation. Assumes ticks are one-cycle pulses.
 */
`timescale 1ns/1ns
`default_nettype none

module cd_divider
    import cd_pkg::*;
#(
    parameter bit SKEW_EN = 1'b0
) (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_rst,
    // Divider bundle
    cd_div_if.div_end port
);

    logic [CD_DIVW-1:0] div_r;
    logic [CD_DIVW-1:0] cnt_r;
    logic [CD_SELW-1:0] sel_r;
    logic [CD_SKEWW-1:0] skew_r;
    logic [CD_DLY-2:0] dly_r;
    logic out_r;
    logic clk_r;
    logic rise_r;
    wire logic src_tick;
    wire logic last;
    wire logic wrap;
    wire logic [CD_DIVW-1:0] div_req;
    wire logic [CD_DIVW-1:0] div_nxt;
    wire logic [CD_DIVW-1:0] cnt_nxt;
    wire logic [CD_DIVW-1:0] hi_nxt;
    wire logic out_nxt;
    wire logic [CD_DLY-1:0] taps;
    wire logic tap;

    assign src_tick = port.ticks[sel_r];
    assign last = (cnt_r == div_r - CD_DIV_ONE);
    assign wrap = src_tick && last;
    // Ratios below two would give no low phase, so they are raised.
    assign div_req = (port.div < CD_DIV_MIN) ? CD_DIV_MIN : port.div;
    assign div_nxt = wrap ? div_req : div_r;
    assign cnt_nxt = !src_tick ? cnt_r : (last ? '0 : cnt_r + CD_DIV_ONE);
    assign hi_nxt = div_nxt - (div_nxt >> 1);
    assign out_nxt = src_tick ? (cnt_nxt < hi_nxt) : out_r;
    assign taps = {dly_r, out_r};
    assign tap = taps[skew_r];
    assign port.clk = clk_r;
    assign port.rise = rise_r;

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            div_r <= CD_DIV_MIN;
            cnt_r <= CD_DIV_MIN - CD_DIV_ONE;
            sel_r <= '0;
            skew_r <= '0;
            out_r <= 1'b0;
        end else begin
            div_r <= div_nxt;
            cnt_r <= cnt_nxt;
            out_r <= out_nxt;
            if (wrap) begin
                sel_r <= port.sel;
                skew_r <= SKEW_EN ? port.skew : '0;
            end
        end
    end

    // Outputs move only on a master clock edge, so no runt reaches the tree.
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            dly_r <= '0;
            clk_r <= 1'b0;
            rise_r <= 1'b0;
        end else begin
            dly_r <= {dly_r[CD_DLY-3:0], out_r};
            clk_r <= tap;
            rise_r <= tap && !clk_r;
        end
    end

    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_rst);

    sequence s_period_end;
        src_tick && last;
    endsequence

    sequence s_mid_period;
        !(src_tick && last);
    endsequence

    AST_DIV_FLOOR: assert property (div_r >= CD_DIV_MIN)
        else $error("divisor below two");
    AST_CFG_HOLD: assert property (
        s_mid_period |=> $stable(div_r) && $stable(sel_r))
        else $error("divider settings changed mid period");
    AST_OUT_ON_TICK: assert property (!src_tick |=> $stable(out_r))
        else $error("divider output moved without a source tick");
    AST_PERIOD_START: assert property (
        s_period_end |=> out_r && cnt_r == '0)
        else $error("period did not restart high");
    AST_HALF_LOW: assert property (
        src_tick && cnt_nxt == hi_nxt |=> !out_r)
        else $error("output not low at half period");

endmodule : cd_divider

`default_nettype wire

//--- verification/cd_src_model.sv
/*
 * Behavioural model of the seven raw clock sources that feed the
 * distribution block. Assumes it shares the master clock of the bench,
 * so every source edge lands a whole number of master cycles apart.
 */
`timescale 1ns/1ns
`default_nettype none

module cd_src_model
    import cd_pkg::*;
#(
    parameter int HALF [CD_NSRC] = '{4, 6, 8, 2, 10, 12, 5}
) (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_rst,
    // Source clocks toward the block
    output logic [CD_NSRC-1:0] o_src
);

    ////////////////////////////////////////////////////////////////////////
    // Each source toggles after its own half period. Every half period is
    // two master cycles or more, so no source outruns the synchronisers.
    int cnt [CD_NSRC];

    always_ff @(posedge i_clock or posedge i_rst) begin
        for (int k = 0; k < CD_NSRC; k++) begin
            if (i_rst) begin
                cnt[k] <= 0;
                o_src[k] <= 1'b0;
            end else if (cnt[k] == HALF[k] - 1) begin
                cnt[k] <= 0;
                o_src[k] <= ~o_src[k];
            end else begin
                cnt[k] <= cnt[k] + 1;
            end
        end
    end

endmodule : cd_src_model

`default_nettype wire

//--- verification/clock_distribution_dividers_bench.sv
/*
 * Self-checking bench of the clock distribution block.
 * Assumes a 50 MHz master clock and sources made by cd_src_model.
 */
`timescale 1ns/1ns
`default_nettype none

module clock_distribution_dividers_bench;
    import cd_pkg::*;

    // Source 3 is the fastest, so it must win the master clock choice.
    localparam int HALF [CD_NSRC] = '{4, 6, 8, 2, 10, 12, 5};

    logic i_clock = 1'b0;
    logic i_rst = 1'b1;
    logic [CD_NSRC-1:0] i_src;
    logic i_chain;
    logic [CD_AW-1:0] i_addr = 8'h00;
    logic [31:0] i_wdata = 32'h0000_0000;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic [31:0] o_rdata;
    logic [CD_SELW-1:0] o_mclk_sel;
    logic o_bus_clk;
    logic o_cpu_clk;
    logic [CD_NDIG-1:0] o_dclk;
    logic [CD_NANA-1:0] o_aclk;
    logic [1:0] o_usb_sel;
    logic o_usb_dbl_en;
    logic [13:0] clks;
    logic [31:0] seed = 32'h0000_000e;
    int fails = 0;
    int tests_run = 0;

    always #10 i_clock = ~i_clock;

    // Digital clock 0 leaves through the interconnect and comes back.
    assign i_chain = o_dclk[0];
    assign clks = {o_aclk, o_dclk, o_cpu_clk, o_bus_clk};

    cd_src_model #(.HALF(HALF)) src_u (
        .i_clock(i_clock), .i_rst(i_rst), .o_src(i_src)
    );

    cd_clock_dist dut_u (
        .i_clock(i_clock), .i_rst(i_rst), .i_src(i_src),
        .i_chain(i_chain), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .o_mclk_sel(o_mclk_sel), .o_bus_clk(o_bus_clk),
        .o_cpu_clk(o_cpu_clk), .o_dclk(o_dclk), .o_aclk(o_aclk),
        .o_usb_sel(o_usb_sel), .o_usb_dbl_en(o_usb_dbl_en)
    );

    ////////////////////////////////////////////////////////////////////////
    function automatic int eff(input int n);
        return (n < 2) ? 2 : n;
    endfunction : eff

    function automatic int sel_of(input int i);
        return (i == 7) ? 7 : ((i % 2 == 1) ? 3 : 0);
    endfunction : sel_of

    // Chained input period follows digital divider 0, which uses source 0.
    function automatic int src_period(input int sel, input int d0);
        return (sel == 7) ? 2 * HALF[0] * eff(d0) : 2 * HALF[sel];
    endfunction : src_period

    function automatic logic [31:0] rnd();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed;
    endfunction : rnd

    task automatic check(input logic [31:0] got, input logic [31:0] want);
        tests_run++;
        if (got !== want) begin
            $display("MISMATCH at %0t: got %h want %h", $time, got, want);
            fails++;
        end
    endtask : check

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clock);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clock);
        i_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge i_clock);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clock);
        i_rd <= 1'b0;
        @(negedge i_clock);
        d = o_rdata;
    endtask : rd

    task automatic wait_lvl(input int idx, input logic v, output int n);
        n = 0;
        while (clks[idx] !== v && n < 4000) begin
            @(negedge i_clock);
            n++;
        end
        // A clock that never reaches the level is a failure in itself.
        if (clks[idx] !== v) begin
            $display("MISMATCH at %0t: clock %0d stuck", $time, idx);
            fails++;
        end
    endtask : wait_lvl

    task automatic measure(input int idx, output int hi, output int lo);
        int n;
        wait_lvl(idx, 1'b0, n);
        wait_lvl(idx, 1'b1, n);
        wait_lvl(idx, 1'b0, hi);
        wait_lvl(idx, 1'b1, lo);
    endtask : measure

    task automatic tally_and_finish();
        if (fails == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : tally_and_finish

    initial begin
        #1_500_000;
        $display("MISMATCH at %0t: watchdog expired", $time);
        fails++;
        tally_and_finish();
    end

    ////////////////////////////////////////////////////////////////////////
    initial begin
        logic [31:0] d;
        logic [31:0] r;
        logic [31:0] want;
        logic [7:0] a8;
        int dv [CD_NDIG];
        int hi;
        int lo;
        int n;
        int p;
        repeat (2) @(posedge i_clock);
        i_rst <= 1'b0;
        // Reset values, unmapped holes included; status is skipped.
        for (int a = 0; a < 'h58; a += 4) begin
            if (a != 'h10) begin
                rd(8'(a), d);
                want = (a == 0) ? CD_MCLK_RST : ((a == 4 || a == 8 ||
                    (a >= 'h20 && a < 'h50)) ? CD_CFG_RST : 32'h0);
                check(d, want);
            end
        end
        for (n = 0; n < 1000 && o_mclk_sel !== 3'h3; n++) @(negedge i_clock);
        check(o_mclk_sel, 32'h3);
        wr(CD_OFF_BUS, 32'h3);
        wr(CD_OFF_CPU, 32'h4);
        repeat (60) @(negedge i_clock);
        measure(0, hi, lo);
        check(hi, 2);
        check(lo, 1);
        measure(1, hi, lo);
        check(hi, 6);
        check(lo, 6);
        wr(CD_OFF_BUS, 32'h2);
        // Random readback; divisors kept small and the chain input avoided.
        for (int i = 0; i < CD_NDIG + 1; i++) begin
            r = rnd();
            r[15:4] = 12'h000;
            r[18] = 1'b0;
            a8 = (i < CD_NDIG) ? CD_OFF_DIG + 8'(4 * i) : CD_OFF_ANA + 8'hc;
            wr(a8, r);
            rd(a8, d);
            check(d, r & ((i < CD_NDIG) ? CD_DIG_MASK : CD_ANA_MASK));
        end
        // Analog divider 3 keeps the random ratio and source written above.
        repeat (300) @(negedge i_clock);
        measure(13, hi, lo);
        p = 2 * HALF[r[17:16]];
        check(hi, (eff(int'(r[3:0])) + 1) / 2 * p);
        check(lo, eff(int'(r[3:0])) / 2 * p);
        // Random ratios with divisors 1 and 0 as corners.
        for (int i = 0; i < CD_NDIG; i++) begin
            r = rnd();
            dv[i] = (i == 2) ? 1 : ((i == 5) ? 0 : 2 + int'(r[2:0]) % 6);
            wr(CD_OFF_DIG + 8'(4 * i), {13'h0, 3'(sel_of(i)), 16'(dv[i])});
        end
        repeat (900) @(negedge i_clock);
        for (int i = 0; i < CD_NDIG; i++) begin
            p = src_period(sel_of(i), dv[0]);
            measure(2 + i, hi, lo);
            check(hi, (eff(dv[i]) + 1) / 2 * p);
            check(lo, eff(dv[i]) / 2 * p);
        end
        // Same phase and ratio, so only the skew separates the two.
        wr(CD_OFF_ANA, 32'h0000_0002);
        wr(CD_OFF_ANA + 8'h4, 32'h0030_0002);
        wr(CD_OFF_ANA + 8'h8, 32'h0003_0004);
        repeat (100) @(negedge i_clock);
        wait_lvl(10, 1'b0, n);
        wait_lvl(10, 1'b1, n);
        wait_lvl(11, 1'b1, n);
        check(n, 3);
        measure(12, hi, lo);
        check(hi, 8);
        check(lo, 8);
        // A new ratio written mid-high must not cut the running period.
        wr(CD_OFF_DIG + 8'h10, 32'h0000_0008);
        repeat (700) @(negedge i_clock);
        wait_lvl(6, 1'b0, n);
        wait_lvl(6, 1'b1, n);
        fork
            wr(CD_OFF_DIG + 8'h10, 32'h0000_0002);
        join_none
        wait_lvl(6, 1'b0, hi);
        wait_lvl(6, 1'b1, lo);
        check(hi, 32);
        check(lo, 32);
        measure(6, hi, lo);
        check(hi, 8);
        check(lo, 8);
        for (int v = 0; v < 4; v++) begin
            wr(CD_OFF_USB, 32'(v));
            for (n = 0; n < 50 && o_usb_sel !== 2'(v); n++) @(negedge i_clock);
            check(o_usb_sel, 32'(v));
            check(o_usb_dbl_en, 32'(v != 0));
            rd(CD_OFF_USB, d);
            check(d, 32'(v * 17));
        end
        wr(CD_OFF_MCLK, 32'h0000_0050);
        for (n = 0; n < 600 && o_mclk_sel !== 3'h5; n++) @(negedge i_clock);
        check(o_mclk_sel, 32'h5);
        tally_and_finish();
    end

endmodule : clock_distribution_dividers_bench

`default_nettype wire
